// ---- verilog/ddr_sram_core.sv ----
// Separate-I/O DDR burst-of-two SRAM core with echo clocks
//
// Behaviour
// - Sample read-select and address on input clock rise
// - Read beats one cycle, then half cycle later
// - Read deselect floats both output beat slots
// - Write-select on clock rise, address on complement
// - Data beat one with command, two with address
// - Write-select high stores nothing
// - Byte masks sampled with their own data beat
// - High mask keeps stored byte unchanged
// - Each write is two beats, bytes masked independently
// - One port never interrupts the other
// - Transfers in progress always run to completion
// - Fully deselected, echo clocks still toggle
// - Echo clocks follow output register firing
// - Output clocks fire outputs, input clocks if tied
// - Selects, address, data and masks captured only on input clock edges
// - Periodic evaluation moves impedance one step
// - Pull-down/pull-up updates only in safe drive state
// - Output impedance settles after 32K clock cycles
// - Same-cycle read/write address passes new data
// - Read after write returns the written data
// - Alternating reads and writes start with either
`default_nettype none

module ddr_sram_core
    import ddr_sram_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int IMP_W = IMP_W_DEF,
    parameter int EVAL_PERIOD = EVAL_PERIOD_DEF,
    parameter int STARTUP_CYCLES = STARTUP_K_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_clk_i,
    input wire logic in_clk_n_i,
    input wire logic out_clk_i,
    input wire logic out_clk_n_i,
    input wire logic rd_sel_n_i,
    input wire logic wr_sel_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] d_i,
    input wire logic [DATA_W/BYTE_W-1:0] byte_lane_mask_n_i,
    input wire logic [IMP_W-1:0] impedance_target_i,
    output logic [DATA_W-1:0] q_o,
    output logic q_oe_o,
    output logic echo_clock_out_o,
    output logic echo_clock_out_n_o,
    output logic [IMP_W-1:0] pu_code_o,
    output logic [IMP_W-1:0] pd_code_o,
    output logic impedance_ready_o
);

    localparam int BYTES = DATA_W / BYTE_W;
    localparam int PIN_W = ADDR_W + DATA_W + BYTES;
    localparam int CTRL_W = $bits(ctrl_pins_t);
    localparam int TIE_W = $clog2(TIE_DETECT_CYCLES + 1);
    localparam int DEPTH = 2 ** (ADDR_W + 1);

    // ------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------------
    ctrl_pins_t ctrl_raw;
    ctrl_pins_t ctrl_s;
    ctrl_pins_t ctrl_p_q;
    clk_edges_t edg;
    logic [CTRL_W-1:0] ctrl_s_bits;
    logic [PIN_W-1:0] pin_s_bits;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] d_s;
    logic [BYTES-1:0] bw_n_s;

    assign ctrl_raw = {in_clk_i, in_clk_n_i, out_clk_i, out_clk_n_i,
                       rd_sel_n_i, wr_sel_n_i};
    assign ctrl_s = ctrl_pins_t'(ctrl_s_bits);
    assign {addr_s, d_s, bw_n_s} = pin_s_bits;

    // Control and data share one latency, so they stay aligned
    pin_sync #(
        .W(CTRL_W)
    ) u_sync_ctrl (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .raw_i(ctrl_raw),
        .stable_o(ctrl_s_bits)
    );

    pin_sync #(
        .W(PIN_W)
    ) u_sync_data (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .raw_i({addr_i, d_i, byte_lane_mask_n_i}),
        .stable_o(pin_s_bits)
    );

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_p_q <= '0;
        end else if (ce_i) begin
            ctrl_p_q <= ctrl_s;
        end
    end

    // Selects, address, data and masks are only ever taken on these detected rises
    assign edg.k_rise = ctrl_s.k & ~ctrl_p_q.k;
    assign edg.kn_rise = ctrl_s.k_n & ~ctrl_p_q.k_n;
    assign edg.c_rise = ctrl_s.c & ~ctrl_p_q.c;
    assign edg.cn_rise = ctrl_s.c_n & ~ctrl_p_q.c_n;

    // ------------------------------------------------------------------
    // Output clock source selection
    // ------------------------------------------------------------------
    logic [TIE_W-1:0] tie_cnt_q;
    logic c_tied_q;
    logic fire_t_q;
    logic fire_c_q;

    // Complementary clocks overlap only briefly; a long overlap is a tie
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tie_cnt_q <= '0;
            c_tied_q <= 1'b0;
        end else if (ce_i) begin
            if (ctrl_s.c && ctrl_s.c_n) begin
                if (tie_cnt_q != TIE_W'(TIE_DETECT_CYCLES)) begin
                    tie_cnt_q <= tie_cnt_q + 1'b1;
                end else begin
                    c_tied_q <= 1'b1;
                end
            end else begin
                tie_cnt_q <= '0;
                c_tied_q <= 1'b0;
            end
        end
    end

    // One cycle of delay lets the read stage settle before firing
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fire_t_q <= 1'b0;
            fire_c_q <= 1'b0;
        end else if (ce_i) begin
            fire_t_q <= c_tied_q ? edg.k_rise : edg.c_rise;
            fire_c_q <= c_tied_q ? edg.kn_rise : edg.cn_rise;
        end
    end

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [DEPTH];

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    logic rd_pend_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic stage_v_q;
    logic [DATA_W-1:0] stage_b0_q;
    logic [DATA_W-1:0] stage_b1_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
        end else if (ce_i && edg.k_rise) begin
            rd_pend_q <= ~ctrl_s.rd_sel_n;
            rd_addr_q <= addr_s;
        end
    end

    // The array is read a full cycle after the command, after the
    // same-cycle write has committed, so new data is always returned
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage_v_q <= 1'b0;
            stage_b0_q <= '0;
            stage_b1_q <= '0;
        end else if (ce_i && edg.k_rise) begin
            stage_v_q <= rd_pend_q;
            stage_b0_q <= mem_q[{rd_addr_q, 1'b0}];
            stage_b1_q <= mem_q[{rd_addr_q, 1'b1}];
        end
    end

    // ------------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------------
    logic wr_pend_q;
    logic [DATA_W-1:0] wr_d0_q;
    logic [BYTES-1:0] wr_bw0_n_q;

    // The first beat and its mask travel with the command
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_d0_q <= '0;
            wr_bw0_n_q <= '1;
        end else if (ce_i) begin
            if (edg.k_rise) begin
                wr_pend_q <= ~ctrl_s.wr_sel_n;
                wr_d0_q <= d_s;
                wr_bw0_n_q <= bw_n_s;
            end else if (edg.kn_rise) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Commit on the complement rise with the address and second beat.
    // Read and write paths keep separate state, so neither disturbs
    // the other and any alternation order is accepted.
    always_ff @(posedge clk_sys_i) begin
        if (ce_i && edg.kn_rise && wr_pend_q) begin
            for (int b = 0; b < BYTES; b++) begin
                if (!wr_bw0_n_q[b]) begin
                    mem_q[{addr_s, 1'b0}][b*BYTE_W +: BYTE_W] <=
                        wr_d0_q[b*BYTE_W +: BYTE_W];
                end
                if (!bw_n_s[b]) begin
                    mem_q[{addr_s, 1'b1}][b*BYTE_W +: BYTE_W] <=
                        d_s[b*BYTE_W +: BYTE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Output registers and echo clocks
    // ------------------------------------------------------------------
    out_phase_t phase_q;
    logic [DATA_W-1:0] beat1_q;
    logic beat1_v_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= OUT_IDLE;
            beat1_q <= '0;
            beat1_v_q <= 1'b0;
        end else if (ce_i) begin
            if (fire_t_q) begin
                phase_q <= OUT_BEAT0;
                beat1_q <= stage_b1_q;
                beat1_v_q <= stage_v_q;
            end else if (fire_c_q) begin
                unique case (phase_q)
                    OUT_IDLE: phase_q <= OUT_IDLE;
                    OUT_BEAT0: phase_q <= OUT_BEAT1;
                    OUT_BEAT1: phase_q <= OUT_BEAT1;
                    default: phase_q <= OUT_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= '0;
            q_oe_o <= 1'b0;
        end else if (ce_i) begin
            if (fire_t_q) begin
                q_o <= stage_v_q ? stage_b0_q : '0;
                q_oe_o <= stage_v_q;
            end else if (fire_c_q && phase_q == OUT_BEAT0) begin
                q_o <= beat1_v_q ? beat1_q : '0;
                q_oe_o <= beat1_v_q;
            end
        end
    end

    // Fired by the same events as the data, whatever the selects do
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            echo_clock_out_o <= 1'b0;
            echo_clock_out_n_o <= 1'b1;
        end else if (ce_i) begin
            if (fire_t_q) begin
                echo_clock_out_o <= 1'b1;
                echo_clock_out_n_o <= 1'b0;
            end else if (fire_c_q) begin
                echo_clock_out_o <= 1'b0;
                echo_clock_out_n_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Impedance calibration
    // ------------------------------------------------------------------
    impedance_ctl #(
        .IMP_W(IMP_W),
        .EVAL_PERIOD(EVAL_PERIOD),
        .STARTUP_CYCLES(STARTUP_CYCLES)
    ) u_imp (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .k_rise_i(edg.k_rise),
        .target_i(impedance_target_i),
        .drive_hiz_i(~q_oe_o),
        .drive_ones_i(&q_o),
        .drive_zeros_i(~|q_o),
        .pu_code_o(pu_code_o),
        .pd_code_o(pd_code_o),
        .ready_o(impedance_ready_o)
    );

endmodule

`default_nettype wire

// ---- verilog/ddr_sram_pkg.sv ----
// Shared constants and carrier types for the burst-of-two DDR SRAM core
`default_nettype none

package ddr_sram_pkg;

    // ------------------------------------------------------------------
    // Geometry defaults
    // ------------------------------------------------------------------
    localparam int DATA_W_DEF = 18;
    localparam int BYTE_W = 9;
    localparam int ADDR_W_DEF = 19;
    localparam int IMP_W_DEF = 6;

    // ------------------------------------------------------------------
    // Timing counts (system clock cycles unless stated)
    // ------------------------------------------------------------------
    // Both output clocks high this long means they are tied off
    localparam int TIE_DETECT_CYCLES = 32;
    // Impedance evaluation interval
    localparam int EVAL_PERIOD_DEF = 1024;
    // Start-up count, in input clock cycles
    localparam int STARTUP_K_CYCLES = 32768;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic rd_sel_n;
        logic wr_sel_n;
    } ctrl_pins_t;

    typedef struct packed {
        logic k_rise;
        logic kn_rise;
        logic c_rise;
        logic cn_rise;
    } clk_edges_t;

    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_BEAT0 = 2'b01,
        OUT_BEAT1 = 2'b11
    } out_phase_t;

endpackage

`default_nettype wire

// ---- verilog/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] raw_i,
    output logic [W-1:0] stable_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce_i) begin
            s1_q <= raw_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit only moves once the last two stages agree
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stable_o <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stable_o[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// ---- verilog/impedance_ctl.sv ----
// Output driver impedance calibration and start-up counter
`default_nettype none

module impedance_ctl
    import ddr_sram_pkg::*;
#(
    parameter int IMP_W = IMP_W_DEF,
    parameter int EVAL_PERIOD = EVAL_PERIOD_DEF,
    parameter int STARTUP_CYCLES = STARTUP_K_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic k_rise_i,
    input wire logic [IMP_W-1:0] target_i,
    input wire logic drive_hiz_i,
    input wire logic drive_ones_i,
    input wire logic drive_zeros_i,
    output logic [IMP_W-1:0] pu_code_o,
    output logic [IMP_W-1:0] pd_code_o,
    output logic ready_o
);

    localparam logic [IMP_W-1:0] CODE_RST = IMP_W'(1 << (IMP_W - 1));

    logic [$clog2(EVAL_PERIOD)-1:0] eval_cnt_q;
    logic [$clog2(STARTUP_CYCLES+1)-1:0] start_cnt_q;
    logic eval;
    logic pu_pend_q;
    logic pd_pend_q;
    logic pu_ok;
    logic pd_ok;

    assign eval = (eval_cnt_q == ($clog2(EVAL_PERIOD))'(EVAL_PERIOD - 1));
    assign pd_ok = drive_hiz_i | drive_ones_i;
    assign pu_ok = drive_hiz_i | drive_zeros_i;

    // ------------------------------------------------------------------
    // Free-running evaluation counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            eval_cnt_q <= '0;
        end else if (ce_i) begin
            eval_cnt_q <= eval ? '0 : eval_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Step codes one unit toward target, only in a safe drive state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pu_code_o <= CODE_RST;
            pu_pend_q <= 1'b0;
        end else if (ce_i) begin
            if (pu_pend_q && pu_ok && target_i != pu_code_o) begin
                pu_code_o <= (target_i > pu_code_o) ? pu_code_o + 1'b1
                                                    : pu_code_o - 1'b1;
            end
            // A fresh evaluation wins over the clear of the last one
            if (eval) begin
                pu_pend_q <= (target_i != pu_code_o);
            end else if (pu_ok) begin
                pu_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_code_o <= CODE_RST;
            pd_pend_q <= 1'b0;
        end else if (ce_i) begin
            if (pd_pend_q && pd_ok && target_i != pd_code_o) begin
                pd_code_o <= (target_i > pd_code_o) ? pd_code_o + 1'b1
                                                    : pd_code_o - 1'b1;
            end
            if (eval) begin
                pd_pend_q <= (target_i != pd_code_o);
            end else if (pd_ok) begin
                pd_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Start-up: counts input clock cycles whether selected or not
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_cnt_q <= '0;
            ready_o <= 1'b0;
        end else if (ce_i) begin
            if (k_rise_i && !ready_o) begin
                start_cnt_q <= start_cnt_q + 1'b1;
            end
            ready_o <= (start_cnt_q ==
                ($clog2(STARTUP_CYCLES+1))'(STARTUP_CYCLES));
        end
    end

endmodule

`default_nettype wire

// ---- sim/ddr_sram_core_assertions.sv ----
// Port-level concurrent checks for the DDR burst-of-two SRAM core
`default_nettype none

module ddr_sram_core_checker
    import ddr_sram_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,
    parameter int IMP_W = IMP_W_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic in_clk_i,
    input wire logic rd_sel_n_i,
    input wire logic [IMP_W-1:0] impedance_target_i,
    input wire logic [DATA_W-1:0] q_o,
    input wire logic q_oe_o,
    input wire logic echo_clock_out_o,
    input wire logic echo_clock_out_n_o,
    input wire logic [IMP_W-1:0] pu_code_o,
    input wire logic [IMP_W-1:0] pd_code_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    logic [7:0] stall_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stall_q <= 8'h00;
        end else if ($changed(echo_clock_out_o)) begin
            stall_q <= 8'h00;
        end else if (stall_q != 8'hFF) begin
            stall_q <= stall_q + 8'h01;
        end
    end

    sequence k_read_s;
        $rose(in_clk_i) && !rd_sel_n_i;
    endsequence
    sequence k_desel_s;
        $rose(in_clk_i) && rd_sel_n_i;
    endsequence
    sequence beat0_s;
        q_oe_o && $rose(echo_clock_out_o);
    endsequence
    sequence beat1_s;
        q_oe_o && $fell(echo_clock_out_o);
    endsequence

    read_drives_a: assert property (k_read_s |-> ##26 q_oe_o [*8])
        else $error("read slot not driven");
    desel_floats_a: assert property (k_desel_s |-> ##26 !q_oe_o [*8])
        else $error("deselected slot driven");
    beat_half_a: assert property (beat0_s |-> ##[6:10] beat1_s)
        else $error("second beat not half a cycle later");
    q_holds_a: assert property (
        q_oe_o && $past(q_oe_o) && $stable(echo_clock_out_o)
        |-> $stable(q_o))
        else $error("read data changed between firings");
    drop_on_fire_a: assert property (
        $fell(q_oe_o) |-> $rose(echo_clock_out_o))
        else $error("output enable dropped mid burst");

    fire_with_echo_a: assert property (
        $rose(q_oe_o) |-> $rose(echo_clock_out_o))
        else $error("drive started without echo edge");
    echo_inverse_a: assert property (
        echo_clock_out_n_o != echo_clock_out_o)
        else $error("echo pair not complementary");
    echo_alive_a: assert property (stall_q < 8'd100)
        else $error("echo clocks stopped");

    imp_step_a: assert property ($changed(pu_code_o) |->
        pu_code_o == $past(pu_code_o) + 1'b1 ||
        pu_code_o == $past(pu_code_o) - 1'b1)
        else $error("pull-up code moved more than one step");
    imp_toward_a: assert property ($changed(pd_code_o) |->
        (pd_code_o > $past(pd_code_o)) ==
        ($past(impedance_target_i) > $past(pd_code_o)))
        else $error("pull-down code moved away from target");
    eval_spacing_a: assert property (
        $changed(pu_code_o) |=> $stable(pu_code_o) [*8])
        else $error("evaluations too close together");
    pd_safe_a: assert property ($changed(pd_code_o) |->
        !q_oe_o || q_o == '1 || !$past(q_oe_o) || $past(q_o) == '1)
        else $error("pull-down updated while driving zeros");
endmodule

bind ddr_sram_core ddr_sram_core_checker #(
    .DATA_W(DATA_W), .IMP_W(IMP_W)
) u_checker (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .in_clk_i(in_clk_i),
    .rd_sel_n_i(rd_sel_n_i), .impedance_target_i(impedance_target_i),
    .q_o(q_o), .q_oe_o(q_oe_o), .echo_clock_out_o(echo_clock_out_o),
    .echo_clock_out_n_o(echo_clock_out_n_o), .pu_code_o(pu_code_o),
    .pd_code_o(pd_code_o)
);

`default_nettype wire

// ---- sim/mem_ctl_model.sv ----
// Memory controller model: free-running clocks, one command pair a cycle
`default_nettype none

module mem_ctl_model #(
    parameter int AW = 6,
    parameter int DW = 18
) (
    input wire logic untied_i,
    output var logic in_clk_o,
    output logic in_clk_n_o,
    output logic out_clk_o,
    output logic out_clk_n_o,
    output var logic rd_sel_n_o,
    output var logic wr_sel_n_o,
    output var logic [AW-1:0] addr_o,
    output var logic [DW-1:0] d_o,
    output var logic [DW/9-1:0] mask_n_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic c_dly = 1'b0;

    initial begin
        in_clk_o = 1'b0;
        rd_sel_n_o = 1'b1;
        wr_sel_n_o = 1'b1;
        addr_o = '0;
        d_o = '0;
        mask_n_o = '0;
        #3;
        forever #80 in_clk_o = ~in_clk_o;
    end
    assign in_clk_n_o = ~in_clk_o;

    // Output clocks lag by 30 ns when used, else both held high
    always @(in_clk_o) c_dly <= #30 in_clk_o;
    assign out_clk_o = untied_i ? c_dly : 1'b1;
    assign out_clk_n_o = untied_i ? ~c_dly : 1'b1;

    task automatic sync();
        @(negedge in_clk_o);
        #20;
    endtask

    task automatic cyc(input logic rn, input logic [AW-1:0] ra,
        input logic wn, input logic [AW-1:0] wa, input logic [DW-1:0] d0,
        input logic [DW-1:0] d1, input logic [1:0] m0, input logic [1:0] m1);
        rd_sel_n_o <= rn;
        wr_sel_n_o <= wn;
        addr_o <= rn ? ~addr_o : ra;
        d_o <= wn ? ~d_o : d0;
        mask_n_o <= m0;
        @(posedge in_clk_o);
        #20;
        addr_o <= wn ? ~addr_o : wa;
        d_o <= wn ? ~d_o : d1;
        mask_n_o <= m1;
        @(negedge in_clk_o);
        #20;
    endtask
endmodule

`default_nettype wire

// ---- sim/test_ddr_sram_core.sv ----
// Self-checking bench for the DDR burst-of-two SRAM core
`default_nettype none

module test_ddr_sram_core;
    timeunit 1ns;
    timeprecision 100ps;
    import ddr_sram_pkg::*;

    localparam int AW = 6;
    localparam int DW = DATA_W_DEF;
    logic clk_sys_i, rst_n_i, untied, in_clk, in_clk_n, out_clk, out_clk_n;
    logic rd_n, wr_n, q_oe, echo, echo_n, ready, echo_prev;
    logic [AW-1:0] addr;
    logic [DW-1:0] d_in, q;
    logic [DW/BYTE_W-1:0] mask_n;
    logic [IMP_W_DEF-1:0] target, pu, pd;
    int error_cnt, checks_done, tog_cnt, k_cnt;
    logic [DW-1:0] beats[$];

    mem_ctl_model #(.AW(AW), .DW(DW)) u_ctl (.untied_i(untied),
        .in_clk_o(in_clk), .in_clk_n_o(in_clk_n), .out_clk_o(out_clk),
        .out_clk_n_o(out_clk_n), .rd_sel_n_o(rd_n), .wr_sel_n_o(wr_n),
        .addr_o(addr), .d_o(d_in), .mask_n_o(mask_n));

    ddr_sram_core #(.ADDR_W(AW), .EVAL_PERIOD(16), .STARTUP_CYCLES(8)) dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
        .in_clk_i(in_clk), .in_clk_n_i(in_clk_n), .out_clk_i(out_clk),
        .out_clk_n_i(out_clk_n), .rd_sel_n_i(rd_n), .wr_sel_n_i(wr_n),
        .addr_i(addr), .d_i(d_in), .byte_lane_mask_n_i(mask_n),
        .impedance_target_i(target), .q_o(q), .q_oe_o(q_oe),
        .echo_clock_out_o(echo), .echo_clock_out_n_o(echo_n),
        .pu_code_o(pu), .pd_code_o(pd), .impedance_ready_o(ready));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        echo_prev <= echo;
        if (echo !== echo_prev) begin
            tog_cnt++;
            if (q_oe === 1'b1) beats.push_back(q);
        end
    end
    always @(posedge in_clk) k_cnt++;

    task automatic chk(input string nm, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk_beats(input logic [DW-1:0] e0, e1);
        int n = 0;
        while (beats.size() < 2 && n < 200) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (beats.size() < 2) begin
            chk("beat wait", 1, 0);
            report_and_stop();
        end else begin
            chk("first beat", e0, beats.pop_front());
            chk("second beat", e1, beats.pop_front());
        end
    endtask

    task automatic idle(input int n);
        repeat (n) u_ctl.cyc(1'b1, '0, 1'b1, '0, '0, '0, 2'b00, 2'b00);
    endtask

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n,
        input logic [1:0] m);
        merge = {m[1] ? o[17:9] : n[17:9], m[0] ? o[8:0] : n[8:0]};
    endfunction

    task automatic t_startup();
        int n = 0;
        chk("oe after reset", 0, q_oe);
        chk("pu after reset", 6'h20, pu);
        chk("pd after reset", 6'h20, pd);
        chk("ready early", 0, ready);
        while (ready !== 1'b1 && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("start-up count", 1, k_cnt >= 8 && ready === 1'b1);
    endtask

    task automatic t_mask();
        for (int m = 0; m < 4; m++) begin
            u_ctl.cyc(1, '0, 0, 6'h0A, 18'h15A5A, 18'h2C3C3, 2'b00, 2'b00);
            u_ctl.cyc(1, '0, 0, 6'h0A, 18'h0F0F0, 18'h30F0F, m[1:0],
                ~m[1:0]);
            u_ctl.cyc(0, 6'h0A, 1, '0, '0, '0, 2'b11, 2'b11);
            idle(2);
            chk_beats(merge(18'h15A5A, 18'h0F0F0, m[1:0]),
                merge(18'h2C3C3, 18'h30F0F, ~m[1:0]));
        end
    endtask

    task automatic t_desel();
        beats.delete();
        tog_cnt = 0;
        idle(4);
        chk("beats while idle", 0, beats.size());
        chk("echo toggles", 1, tog_cnt >= 7);
        u_ctl.cyc(0, 6'h0A, 1, '0, '0, '0, 2'b00, 2'b00);
        idle(2);
        chk_beats(18'h15A5A, 18'h30F0F);
    endtask

    task automatic t_pass();
        u_ctl.cyc(0, 6'h0A, 0, 6'h21, 18'h11111, 18'h22222, 2'b00, 2'b00);
        u_ctl.cyc(0, 6'h0A, 0, 6'h0A, 18'h0AAAA, 18'h15555, 2'b00, 2'b00);
        u_ctl.cyc(0, 6'h21, 0, 6'h30, 18'h33333, 18'h04444, 2'b00, 2'b00);
        u_ctl.cyc(0, 6'h30, 1, '0, '0, '0, 2'b00, 2'b00);
        idle(2);
        chk_beats(18'h15A5A, 18'h30F0F);
        chk_beats(18'h0AAAA, 18'h15555);
        chk_beats(18'h11111, 18'h22222);
        chk_beats(18'h33333, 18'h04444);
    endtask

    task automatic t_untied();
        untied = 1'b1;
        idle(2);
        u_ctl.cyc(1, '0, 0, 6'h12, 18'h12345, 18'h0ABCD, 2'b00, 2'b00);
        u_ctl.cyc(0, 6'h12, 1, '0, '0, '0, 2'b00, 2'b00);
        idle(2);
        chk_beats(18'h12345, 18'h0ABCD);
        untied = 1'b0;
        idle(4);
    endtask

    task automatic t_imp(input logic [5:0] t);
        int n = 0;
        @(posedge clk_sys_i);
        target <= t;
        while ((pu !== t || pd !== t) && n < 300) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("pull-up code", t, pu);
        chk("pull-down code", t, pd);
    endtask

    initial begin
        rst_n_i = 1'b0;
        target = 6'h20;
        untied = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        k_cnt = 0;
        @(posedge clk_sys_i);
        t_startup();
        u_ctl.sync();
        t_mask();
        t_desel();
        t_pass();
        t_untied();
        t_imp(6'h23);
        t_imp(6'h1D);
        report_and_stop();
    end
endmodule

`default_nettype wire
